// >>> design/bcwd_decoder.sv
// Boot configuration word decoder: samples the clock/watchdog word and the
// PLL word once after reset, decodes the clock/watchdog word and holds the settings.
// Assumes the config words are stable from reset release until loaded.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Window size code picks 25/37.5/50/75 percent
// - Force bit runs watchdog, software cannot stop
// - Window-disable bit selects non-window mode
// - Postscale code doubles ratio, 1:4 at 00010
// - Codes above 10100 act as 10100
// - Switching and monitor enables from two-bit code
// - Peripheral bus divisor codes give 1,2,4,8
// - Clock out only when enabled and mode 11/00
// - Primary oscillator mode off/HS/standard/external
// - Switchover bit enables two-speed start-up
// - Secondary oscillator enable follows its bit
// - Three-bit code selects oscillator source
module bcwd_decoder
  import bcwd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] cfgWord1,
  input wire logic [31:0] cfgWord2,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output bcwd_wd_type wdSettings,
  output bcwd_clk_type clkSettings,
  output logic wdRunning,
  output logic configValid,
  output logic configWarning
);

  // Load sequencer state
  bcwd_load_type loadState;
  bcwd_load_type next_loadState;
  logic [31:0] word1;
  logic wdSoftEnable;
  logic [31:0] storeData;

  // Postscale: log2 of ratio, clamped above the highest code
  function automatic logic [4:0] postscaleLog2(input logic [4:0] code);
    if (code > PS_CODE_MAX) begin
      return PS_CODE_MAX;
    end
    return code;
  endfunction : postscaleLog2

  // Open window in eighths of the timeout
  function automatic logic [3:0] windowEighths(input logic [1:0] code);
    logic [3:0] w;
    w = WIN_EIGHTHS_00;
    unique case (code)
      2'b11: w = WIN_EIGHTHS_11;
      2'b10: w = WIN_EIGHTHS_10;
      2'b01: w = WIN_EIGHTHS_01;
      2'b00: w = WIN_EIGHTHS_00;
    endcase
    return w;
  endfunction : windowEighths

  // Field selects of the held word
  wire [1:0] winCode = word1[WIN_SIZE_LSB +: 2];
  wire forceBit = word1[WD_FORCE_BIT];
  wire winDisBit = word1[WIN_DIS_BIT];
  wire [4:0] psCode = word1[PS_LSB +: 5];
  wire [1:0] csmCode = word1[CSM_LSB +: 2];
  wire [1:0] pbCode = word1[PBDIV_LSB +: 2];
  wire clkOutBit = word1[CLKOUT_BIT];
  wire [1:0] poscCode = word1[POSC_LSB +: 2];
  wire twoSpeedBit = word1[TWO_SPEED_BIT];
  wire soscBit = word1[SOSC_BIT];
  wire [2:0] srcCode = word1[OSC_SRC_LSB +: 3];

  // Decoded watchdog settings
  wire bcwd_wd_type next_wd = '{
    windowEighths: windowEighths(winCode),
    forceEnable: forceBit,
    softEnableAllowed: ~forceBit,
    windowMode: ~winDisBit,
    postscaleLog2: postscaleLog2(psCode)
  };

  // Clock-out is only possible with primary off or external clock
  wire poscAllowsOut = (poscCode == POSC_OFF) || (poscCode == POSC_EXT_CLOCK);
  wire bcwd_clk_type next_clk = '{
    switchEnable: ~csmCode[1],
    monitorEnable: (csmCode == 2'b00),
    periphBusDivisor: 4'h1 << pbCode,
    clockOutput: ~clkOutBit & poscAllowsOut,
    primaryOscMode: bcwd_posc_type'(poscCode),
    twoSpeedStartup: twoSpeedBit,
    secondaryOscEnable: soscBit,
    oscSource: bcwd_src_type'(srcCode)
  };

  // Flag words that break programmer obligations, for software to see
  wire usesPrimary = (srcCode == SRC_PRIMARY) || (srcCode == SRC_PRIMARY_PLL);
  wire badPrimary = usesPrimary && (poscCode == POSC_OFF);
  wire badReserved = (word1[31:26] != 6'h3f) || !word1[21] || !word1[11]
                     || !word1[6] || (word1[4:3] != 2'h3);

  // Sequencer: sample once after reset, then hold
  always_comb begin
    next_loadState = loadState;
    unique case (loadState)
      LD_IDLE: next_loadState = LD_SAMPLE;
      LD_SAMPLE: next_loadState = LD_HOLD;
      LD_HOLD: next_loadState = LD_HOLD;
      default: next_loadState = LD_IDLE;
    endcase
  end

  // Both words go to the store during sampling: word 1 then word 2
  wire storeWr = (loadState != LD_HOLD);
  wire [0:0] storeWrAddr = (loadState == LD_SAMPLE) ? 1'b1 : 1'b0;
  wire [31:0] storeWrData = (loadState == LD_SAMPLE) ? cfgWord2 : cfgWord1;
  // Only word 2 is read back from the store; word 1 is already held here,
  // so the read answer can be registered without a second cycle of latency
  wire [0:0] storeRdAddr = 1'b1;

  bcwd_word_store #(
    .DEPTH(2),
    .WIDTH(32)
  ) u_store (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wrEn(storeWr),
    .wrAddr(storeWrAddr),
    .wrData(storeWrData),
    .rdAddr(storeRdAddr),
    .rdData(storeData)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      loadState <= LD_IDLE;
    end else if (ce) begin
      loadState <= next_loadState;
    end
  end

  // Word 1 captured once; reset value is all ones in every field
  always_ff @(posedge mclk) begin
    if (rst) begin
      word1 <= WORD_RESET;
    end else if (ce && loadState == LD_IDLE) begin
      word1 <= cfgWord1;
    end
  end

  // Decoded outputs refresh only while loading, then stay put
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdSettings <= '0;
      clkSettings <= '0;
      configValid <= 1'b0;
      configWarning <= 1'b0;
    end else if (ce && loadState == LD_SAMPLE) begin
      wdSettings <= next_wd;
      clkSettings <= next_clk;
      configValid <= 1'b1;
      configWarning <= badPrimary | badReserved;
    end
  end

  // Software enable is ignored when the force bit holds the dog on
  wire ctrlWrite = regWrite && (regAddr == ADDR_CTRL);
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdSoftEnable <= CTRL_RESET;
      wdRunning <= 1'b0;
    end else if (ce) begin
      if (ctrlWrite) wdSoftEnable <= regWdata[0];
      wdRunning <= configValid & (wdSettings.forceEnable | wdSoftEnable);
    end
  end

  // Status words for the read path
  wire [31:0] wdStatus = {16'h0, 1'b0, wdSoftEnable, wdRunning,
                          wdSettings.windowMode, wdSettings.softEnableAllowed,
                          wdSettings.forceEnable, wdSettings.windowEighths,
                          1'b0, wdSettings.postscaleLog2};
  wire [31:0] clkStatus = {15'h0, configWarning, configValid, 1'b0,
                           clkSettings.switchEnable, clkSettings.monitorEnable,
                           clkSettings.periphBusDivisor, clkSettings.clockOutput,
                           clkSettings.primaryOscMode, clkSettings.twoSpeedStartup,
                           clkSettings.secondaryOscEnable, clkSettings.oscSource};

  // Read answer selected at the strobe; unmapped addresses read zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = RDATA_RESET;
    if (regRead) begin
      unique case (regAddr)
        ADDR_CFG1_RAW: next_rdata = word1;
        ADDR_CFG2_RAW: next_rdata = storeData;
        ADDR_WD_STATUS: next_rdata = wdStatus;
        ADDR_CLK_STATUS: next_rdata = clkStatus;
        ADDR_CTRL: next_rdata = {31'h0, wdSoftEnable};
        default: next_rdata = RDATA_RESET;
      endcase
    end
  end

  // Registered so the data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= RDATA_RESET;
    end else if (ce) begin
      regRdata <= next_rdata;
    end
  end

endmodule : bcwd_decoder
`default_nettype wire

// >>> design/bcwd_pkg.sv
// Package for the boot configuration word decoder: field positions, codes,
// register offsets and packed carriers for the decoded settings.
// Assumes a 32-bit configuration word delivered by the nonvolatile store.
package bcwd_pkg;

  // Field positions in the clock and watchdog word
  localparam int WIN_SIZE_LSB = 24;
  localparam int WD_FORCE_BIT = 23;
  localparam int WIN_DIS_BIT = 22;
  localparam int PS_LSB = 16;
  localparam int CSM_LSB = 14;
  localparam int PBDIV_LSB = 12;
  localparam int CLKOUT_BIT = 10;
  localparam int POSC_LSB = 8;
  localparam int TWO_SPEED_BIT = 7;
  localparam int SOSC_BIT = 5;
  localparam int OSC_SRC_LSB = 0;

  // Highest postscale code and its power of two
  localparam logic [4:0] PS_CODE_MAX = 5'h14;

  // Register offsets on the plain register port (word index)
  localparam logic [3:0] ADDR_CFG1_RAW = 4'h0;
  localparam logic [3:0] ADDR_CFG2_RAW = 4'h1;
  localparam logic [3:0] ADDR_WD_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CLK_STATUS = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'hffffffff;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  // Open window in eighths of the period
  localparam logic [3:0] WIN_EIGHTHS_11 = 4'h2;
  localparam logic [3:0] WIN_EIGHTHS_10 = 4'h3;
  localparam logic [3:0] WIN_EIGHTHS_01 = 4'h4;
  localparam logic [3:0] WIN_EIGHTHS_00 = 4'h6;

  typedef enum logic [1:0] {
    POSC_EXT_CLOCK = 2'b00,
    POSC_STD_CRYSTAL = 2'b01,
    POSC_HS_CRYSTAL = 2'b10,
    POSC_OFF = 2'b11
  } bcwd_posc_type;

  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'b000,
    SRC_FAST_RC_DIV_N_PLL = 3'b001,
    SRC_PRIMARY = 3'b010,
    SRC_PRIMARY_PLL = 3'b011,
    SRC_SECONDARY = 3'b100,
    SRC_LOW_POWER_RC = 3'b101,
    SRC_FAST_RC_DIV_16 = 3'b110,
    SRC_FAST_RC_DIV_N = 3'b111
  } bcwd_src_type;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_SAMPLE = 2'b01,
    LD_HOLD = 2'b10
  } bcwd_load_type;

  typedef struct packed {
    logic [3:0] windowEighths;
    logic forceEnable;
    logic softEnableAllowed;
    logic windowMode;
    logic [4:0] postscaleLog2;
  } bcwd_wd_type;

  typedef struct packed {
    logic switchEnable;
    logic monitorEnable;
    logic [3:0] periphBusDivisor;
    logic clockOutput;
    bcwd_posc_type primaryOscMode;
    logic twoSpeedStartup;
    logic secondaryOscEnable;
    bcwd_src_type oscSource;
  } bcwd_clk_type;

endpackage : bcwd_pkg

// >>> design/bcwd_word_store.sv
// Small holding store for the two sampled configuration words.
// Assumes the loader asserts the write enable for one cycle per word.
`timescale 1ns/1ps
`default_nettype none
module bcwd_word_store
  import bcwd_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [0:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [0:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // The loader addresses exactly two words with a one-bit index
  if (DEPTH != 2) begin : g_bad_depth
    $error("bcwd_word_store: DEPTH must be 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("bcwd_word_store: WIDTH must be positive");
  end

  // Writes land in the array; read data leave through a register
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData <= WIDTH'(WORD_RESET);
    end else if (ce) begin
      if (wrEn) mem[wrAddr] <= wrData;
      rdData <= mem[rdAddr];
    end
  end

endmodule : bcwd_word_store
`default_nettype wire

// >>> tb/bcwd_monitor.sv
// Checker for the decoded watchdog and clock settings.
// Assumes it is bound to bcwd_decoder; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bcwd_monitor
  import bcwd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] cfgWord1,
  input wire logic [31:0] cfgWord2,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire bcwd_wd_type wdSettings,
  input wire bcwd_clk_type clkSettings,
  input wire logic wdRunning,
  input wire logic configValid,
  input wire logic configWarning
);
  logic seen;
  logic [31:0] cap;
  // Own copy of the word, taken at the first enabled edge after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      seen <= 1'b0;
      cap <= WORD_RESET;
    end else if (ce && !seen) begin
      seen <= 1'b1;
      cap <= cfgWord1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  win_size_a: assert property (configValid |-> wdSettings.windowEighths ==
    (cap[25] ? (cap[24] ? 4'h2 : 4'h3) : (cap[24] ? 4'h4 : 4'h6))) else $error("window size");
  force_en_a: assert property (configValid |->
    wdSettings.forceEnable == cap[23] && wdSettings.softEnableAllowed == !cap[23])
    else $error("force enable");
  win_mode_a: assert property (configValid |-> wdSettings.windowMode == !cap[22])
    else $error("window mode");
  post_scale_a: assert property (configValid |-> wdSettings.postscaleLog2 ==
    ((cap[20:16] > 5'h14) ? 5'h14 : cap[20:16])) else $error("postscale");
  clk_switch_a: assert property (configValid |-> clkSettings.switchEnable == !cap[15] &&
    clkSettings.monitorEnable == (cap[15:14] == 2'h0)) else $error("switch monitor");
  bus_div_a: assert property (configValid |->
    clkSettings.periphBusDivisor == (4'h1 << cap[13:12])) else $error("bus divisor");
  clk_out_a: assert property (configValid |-> clkSettings.clockOutput ==
    (!cap[10] && cap[9] == cap[8])) else $error("clock out");
  osc_fields_a: assert property (configValid |-> clkSettings.primaryOscMode == cap[9:8] &&
    clkSettings.twoSpeedStartup == cap[7] && clkSettings.secondaryOscEnable == cap[5] &&
    clkSettings.oscSource == cap[2:0]) else $error("oscillator fields");
  hold_cfg_a: assert property (configValid && $past(configValid) |->
    $stable(wdSettings) && $stable(clkSettings)) else $error("settings moved");
  wd_forced_a: assert property (configValid && $past(configValid) &&
    wdSettings.forceEnable |-> wdRunning) else $error("forced watchdog idle");
endmodule : bcwd_monitor

bind bcwd_decoder bcwd_monitor u_bcwd_monitor (.mclk(mclk), .rst(rst), .ce(ce),
  .cfgWord1(cfgWord1), .cfgWord2(cfgWord2), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .wdSettings(wdSettings),
  .clkSettings(clkSettings), .wdRunning(wdRunning), .configValid(configValid),
  .configWarning(configWarning));
`default_nettype wire

// >>> tb/bcwd_tb_top.sv
// Testbench for the config word decoder: loads words, checks settings.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none
module bcwd_tb_top
  import bcwd_pkg::*;
;
  logic mclk, rst, ce, regWrite, regRead, wdRunning, configValid, configWarning;
  logic [31:0] cfgWord1, cfgWord2, regWdata, regRdata;
  logic [3:0] regAddr;
  bcwd_wd_type wdSettings;
  bcwd_clk_type clkSettings;
  int badCount = 0;
  int comparisons = 0;
  logic [4:0] psTab [8] = '{5'h02, 5'h14, 5'h15, 5'h1f, 5'h00, 5'h0a, 5'h13, 5'h03};

  bcwd_decoder u_bcwd_decoder (.mclk(mclk), .rst(rst), .ce(ce), .cfgWord1(cfgWord1),
    .cfgWord2(cfgWord2), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .wdSettings(wdSettings),
    .clkSettings(clkSettings), .wdRunning(wdRunning), .configValid(configValid),
    .configWarning(configWarning));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic writeReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : writeReg

  // Data is only valid in the cycle after the strobe
  task automatic readReg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : readReg

  // Word is held steady until the load completes, then disturbed
  task automatic load(input logic [31:0] w);
    @(posedge mclk);
    rst <= 1'b1;
    cfgWord1 <= w;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int n = 0; n < 8 && configValid !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (configValid !== 1'b1) begin
      badCount++;
      summarize();
    end
    @(posedge mclk);
    cfgWord1 <= ~w;
  endtask : load

  function automatic bcwd_wd_type expWd(input logic [31:0] w);
    bcwd_wd_type e;
    e.windowEighths = w[25] ? (w[24] ? 4'h2 : 4'h3) : (w[24] ? 4'h4 : 4'h6);
    e.forceEnable = w[23];
    e.softEnableAllowed = ~w[23];
    e.windowMode = ~w[22];
    e.postscaleLog2 = (w[20:16] > 5'h14) ? 5'h14 : w[20:16];
    return e;
  endfunction : expWd

  function automatic bcwd_clk_type expClk(input logic [31:0] w);
    bcwd_clk_type e;
    e.switchEnable = ~w[15];
    e.monitorEnable = ~w[15] & ~w[14];
    e.periphBusDivisor = 4'h1 << w[13:12];
    e.clockOutput = ~w[10] & (w[9] ~^ w[8]);
    e.primaryOscMode = bcwd_posc_type'(w[9:8]);
    e.twoSpeedStartup = w[7];
    e.secondaryOscEnable = w[5];
    e.oscSource = bcwd_src_type'(w[2:0]);
    return e;
  endfunction : expClk

  // Eight words walk every code of every field except postscale, which gets the eight codes of psTab
  initial begin
    logic [31:0] w;
    logic [31:0] d;
    logic [2:0] k;
    bcwd_wd_type ew;
    rst = 1'b1;
    ce = 1'b1;
    cfgWord1 = 32'hffffffff;
    cfgWord2 = 32'hfff8f7ff;
    regAddr = 4'h0;
    regWdata = 32'h00000000;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      w = {6'h3f, k[1:0], k[0], k[1], 1'b1, psTab[i], k[1:0], ~k[1:0], 1'b1, k[2], k[1:0],
        k[0], 1'b1, k[1], 2'h3, k[2], ~k[1], k[0]};
      load(w);
      readReg(ADDR_CFG1_RAW, d);
      chk("raw word", w, d);
      readReg(ADDR_CFG2_RAW, d);
      chk("raw word 2", 32'hfff8f7ff, d);
      ew = expWd(w);
      readReg(ADDR_WD_STATUS, d);
      chk("wd status", {18'h0, w[23], ew.windowMode, ew.softEnableAllowed, ew.forceEnable,
        ew.windowEighths, 1'b0, ew.postscaleLog2}, d);
      readReg(ADDR_CLK_STATUS, d);
      chk("clk status", {15'h0, 3'b010, expClk(w)}, d);
      chk("wdSettings", 32'(expWd(w)), 32'(wdSettings));
      chk("clkSettings", 32'(expClk(w)), 32'(clkSettings));
      chk("wdRunning", {31'h0, w[23]}, {31'h0, wdRunning});
      writeReg(ADDR_CTRL, 32'h00000001);
      @(posedge mclk);
      #1 chk("soft on", 32'h1, {31'h0, wdRunning});
      writeReg(ADDR_CTRL, 32'h00000000);
      @(posedge mclk);
      #1 chk("soft off", {31'h0, w[23]}, {31'h0, wdRunning});
    end
    readReg(4'hf, d);
    chk("unmapped", 32'h0, d);
    summarize();
  end
endmodule : bcwd_tb_top
`default_nettype wire
